// >>> synth_lock_phase_regs_defines.vh
// Constants for the synthesizer lock and phase register bank.
// Assumes an 8-bit register port with byte addresses.
`ifndef SYNTH_LOCK_PHASE_REGS_DEFINES_VH
`define SYNTH_LOCK_PHASE_REGS_DEFINES_VH

`define ADDR_LOCK_LOSS_STATUS 8'hb9
`define ADDR_LOCK_LOSS_CLEAR 8'hba
`define ADDR_PHASE_C_LO 8'hbf
`define ADDR_PHASE_C_HI 8'hc0
`define ADDR_PHASE_D_LO 8'hc1
`define ADDR_PHASE_D_HI 8'hc2
`define ADDR_OSC_SELECT 8'hc3

`define RST_LOCK_LOSS_CLEAR 8'h00
`define RST_PHASE 16'h0000
`define RST_OSC_SELECT 8'h00
`define RST_STICKY 1'b1
`define RST_CLEAR_BIT 1'b0
`define RST_STAGE 8'h00
`define RST_COARSE 13'h0
`define RST_EIGHTH 3'h0
`define RST_STEPS 4'h0
`define RST_OSC_DISABLE 1'b0
`define RST_DRIVE_EN 1'b1
`define RST_RD_DATA 8'h00
`define RD_UNMAPPED 8'h00

`define BIT_LOCK_LOST 0
`define BIT_CLEAR 0
`define BIT_OSC_DISABLE 0
`define COARSE_MSB 12
`define EIGHTH_LSB 13
`define EIGHTH_MSB 15

`endif

// >>> synth_lock_phase_regs.v
// Register bank for synthesizer lock status, divider phase offsets and
// the master-oscillator driver select.
// Assumes a simple synchronous byte register port: wr_en/rd_en with an
// 8-bit address, all inputs but the asynchronous reset arst_n synchronous to mclk.
// Assumes the synthesizer reports loss of lock on lock_lost_event, one
// capture per sampled high cycle, in the mclk domain.
`include "synth_lock_phase_regs_defines.vh"

module synth_lock_phase_regs (
	input wire mclk,
	input wire arst_n,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] addr,
	input wire [7:0] wr_data,
	input wire lock_lost_event,
	output reg [7:0] rd_data,
	output reg lock_lost_sticky,
	output reg lock_lost_clear,
	output reg [12:0] coarse_offset_div_c,
	output reg [2:0] eighth_turn_offset_div_c,
	output reg signed [3:0] eighth_turn_steps_div_c,
	output reg [12:0] coarse_offset_div_d,
	output reg [2:0] eighth_turn_offset_div_d,
	output reg signed [3:0] eighth_turn_steps_div_d,
	output reg osc_driver_disable,
	output reg master_osc_drive_en
);

	// ****************************************************************
	// Staging of phase low bytes
	// ****************************************************************
	// The low byte waits here so the divider never sees half an update.
	reg [7:0] stage_c_q;
	reg [7:0] stage_d_q;
	reg [15:0] phase_c_d;
	reg [15:0] phase_d_d;

	always @* begin
		phase_c_d = {wr_data, stage_c_q};
		phase_d_d = {wr_data, stage_d_q};
	end

	// Signed eighth-turn steps: -1 per -45 degrees, 4 stands for 180.
	function [3:0] eighth_steps;
		input [2:0] code;
		begin
			case (code)
				3'h0: eighth_steps = 4'h0;
				3'h1: eighth_steps = 4'hf;
				3'h2: eighth_steps = 4'he;
				3'h3: eighth_steps = 4'hd;
				3'h4: eighth_steps = 4'h4;
				3'h5: eighth_steps = 4'h3;
				3'h6: eighth_steps = 4'h2;
				default: eighth_steps = 4'h1;
			endcase
		end
	endfunction

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// One strobe per writable register. The status byte has no strobe, so a
	// write to it, like a write to an unmapped address, is simply dropped.
	wire clear_wr;
	wire phase_c_lo_wr;
	wire phase_c_hi_wr;
	wire phase_d_lo_wr;
	wire phase_d_hi_wr;
	wire osc_wr;

	// The eighth-turn code is taken from the assembled word, not the bus.
	wire [2:0] eighth_code_c;
	wire [2:0] eighth_code_d;
	wire [3:0] steps_c_d;
	wire [3:0] steps_d_d;

	assign clear_wr = wr_en && (addr == `ADDR_LOCK_LOSS_CLEAR);
	assign phase_c_lo_wr = wr_en && (addr == `ADDR_PHASE_C_LO);
	assign phase_c_hi_wr = wr_en && (addr == `ADDR_PHASE_C_HI);
	assign phase_d_lo_wr = wr_en && (addr == `ADDR_PHASE_D_LO);
	assign phase_d_hi_wr = wr_en && (addr == `ADDR_PHASE_D_HI);
	assign osc_wr = wr_en && (addr == `ADDR_OSC_SELECT);

	assign eighth_code_c = phase_c_d[`EIGHTH_MSB:`EIGHTH_LSB];
	assign eighth_code_d = phase_d_d[`EIGHTH_MSB:`EIGHTH_LSB];
	assign steps_c_d = eighth_steps(eighth_code_c);
	assign steps_d_d = eighth_steps(eighth_code_d);

	// ****************************************************************
	// Lock status
	// ****************************************************************
	// Clear is a level, not a pulse: a lock loss seen while it is high is
	// dropped, so software must lower the bit before losses are captured.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_lost_sticky <= `RST_STICKY;
		end else if (lock_lost_clear) begin
			lock_lost_sticky <= 1'b0;
		end else if (lock_lost_event) begin
			lock_lost_sticky <= 1'b1;
		end
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			lock_lost_clear <= `RST_CLEAR_BIT;
		end else if (clear_wr) begin
			lock_lost_clear <= wr_data[`BIT_CLEAR];
		end
	end

	// ****************************************************************
	// Phase low-byte capture
	// ****************************************************************
	// A low byte written twice before its high byte keeps only the last one.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage_c_q <= `RST_STAGE;
			stage_d_q <= `RST_STAGE;
		end else begin
			if (phase_c_lo_wr) begin
				stage_c_q <= wr_data;
			end
			if (phase_d_lo_wr) begin
				stage_d_q <= wr_data;
			end
		end
	end

	// ****************************************************************
	// Divider C phase
	// ****************************************************************
	// Coarse and eighth-turn fields change on the same edge, so the divider
	// never runs with a mix of old and new settings.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			coarse_offset_div_c <= `RST_COARSE;
			eighth_turn_offset_div_c <= `RST_EIGHTH;
			eighth_turn_steps_div_c <= `RST_STEPS;
		end else if (phase_c_hi_wr) begin
			coarse_offset_div_c <= phase_c_d[`COARSE_MSB:0];
			eighth_turn_offset_div_c <= eighth_code_c;
			eighth_turn_steps_div_c <= steps_c_d;
		end
	end

	// ****************************************************************
	// Divider D phase
	// ****************************************************************
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			coarse_offset_div_d <= `RST_COARSE;
			eighth_turn_offset_div_d <= `RST_EIGHTH;
			eighth_turn_steps_div_d <= `RST_STEPS;
		end else if (phase_d_hi_wr) begin
			coarse_offset_div_d <= phase_d_d[`COARSE_MSB:0];
			eighth_turn_offset_div_d <= eighth_code_d;
			eighth_turn_steps_div_d <= steps_d_d;
		end
	end

	// ****************************************************************
	// Master-oscillator driver select
	// ****************************************************************
	// The enable is its own flop rather than an inverter on the select, so
	// the pin driver sees a registered level with no decode glitch.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			osc_driver_disable <= `RST_OSC_DISABLE;
			master_osc_drive_en <= `RST_DRIVE_EN;
		end else if (osc_wr) begin
			osc_driver_disable <= wr_data[`BIT_OSC_DISABLE];
			master_osc_drive_en <= ~wr_data[`BIT_OSC_DISABLE];
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Reserved bits and unmapped addresses read zero. A read in the same
	// cycle as a write to the same address returns the old value.
	reg [7:0] rd_data_d;

	always @* begin
		rd_data_d = `RD_UNMAPPED;
		case (addr)
			`ADDR_LOCK_LOSS_STATUS: rd_data_d = {7'h00, lock_lost_sticky};
			`ADDR_LOCK_LOSS_CLEAR: rd_data_d = {7'h00, lock_lost_clear};
			`ADDR_PHASE_C_LO: rd_data_d = coarse_offset_div_c[7:0];
			`ADDR_PHASE_C_HI: rd_data_d = {eighth_turn_offset_div_c, coarse_offset_div_c[12:8]};
			`ADDR_PHASE_D_LO: rd_data_d = coarse_offset_div_d[7:0];
			`ADDR_PHASE_D_HI: rd_data_d = {eighth_turn_offset_div_d, coarse_offset_div_d[12:8]};
			`ADDR_OSC_SELECT: rd_data_d = {7'h00, osc_driver_disable};
			default: rd_data_d = `RD_UNMAPPED;
		endcase
	end

	// The read byte holds between reads, so a slow host may sample it late.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= `RST_RD_DATA;
		end else if (rd_en) begin
			rd_data <= rd_data_d;
		end
	end

endmodule

// >>> synth_lock_phase_regs_props.sv
// Checker for the lock and phase register bank.
// Bound to the bank top; sees its ports only.
`include "synth_lock_phase_regs_defines.vh"
module synth_lock_phase_regs_props (
	input wire mclk,
	input wire arst_n,
	input wire wr_en,
	input wire rd_en,
	input wire lock_lost_event,
	input wire [7:0] addr,
	input wire [7:0] wr_data,
	input wire [7:0] rd_data,
	input wire lock_lost_sticky,
	input wire lock_lost_clear,
	input wire [12:0] coarse_offset_div_c,
	input wire [2:0] eighth_turn_offset_div_c,
	input wire signed [3:0] eighth_turn_steps_div_c,
	input wire [12:0] coarse_offset_div_d,
	input wire [2:0] eighth_turn_offset_div_d,
	input wire signed [3:0] eighth_turn_steps_div_d,
	input wire osc_driver_disable,
	input wire master_osc_drive_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_sticky_holds: assert property (lock_lost_sticky && !lock_lost_clear |=> lock_lost_sticky)
		else $error("flag dropped");
	a_event_sets: assert property (lock_lost_event && !lock_lost_clear |=> lock_lost_sticky)
		else $error("loss missed");
	a_clear_holds: assert property (lock_lost_clear |=> !lock_lost_sticky)
		else $error("clear ignored");
	a_reset_sets: assert property ($rose(arst_n) |-> lock_lost_sticky)
		else $error("flag low after reset");
	a_osc_write: assert property (wr_en && addr == `ADDR_OSC_SELECT |=>
		osc_driver_disable == $past(wr_data[0])) else $error("select bad");
	a_quad_decode: assert property (eighth_turn_steps_div_c ==
		(eighth_turn_offset_div_c[2] ? 4'h8 : 4'h0) - eighth_turn_offset_div_c) else $error("decode");
	a_low_staged: assert property (wr_en && addr == `ADDR_PHASE_C_LO |=>
		$stable(coarse_offset_div_c)) else $error("low byte leaked");
	a_high_applies: assert property (wr_en && addr == `ADDR_PHASE_C_HI |=>
		eighth_turn_offset_div_c == $past(wr_data[7:5])) else $error("quad bad");
	a_status_read: assert property (rd_en && addr == `ADDR_LOCK_LOSS_STATUS |=>
		rd_data == {7'h00, $past(lock_lost_sticky)}) else $error("status bad");
	a_quad_decode_d: assert property (eighth_turn_steps_div_d ==
		(eighth_turn_offset_div_d[2] ? 4'h8 : 4'h0) - eighth_turn_offset_div_d) else $error("decode d");
	a_high_applies_d: assert property (wr_en && addr == `ADDR_PHASE_D_HI |=>
		eighth_turn_offset_div_d == $past(wr_data[7:5])) else $error("quad d bad");
	a_clear_write: assert property (wr_en && addr == `ADDR_LOCK_LOSS_CLEAR |=>
		lock_lost_clear == $past(wr_data[0])) else $error("clear bit bad");
	a_drive_inverse: assert property (master_osc_drive_en == !osc_driver_disable)
		else $error("driver enable bad");
	cover property (lock_lost_clear && lock_lost_event);
	cover property (wr_en && addr == `ADDR_PHASE_C_HI);
	cover property ($rose(osc_driver_disable));
	cover property ($rose(arst_n));
endmodule

// >>> testbench.sv
// Self-checking bench for the lock and phase register bank.
// Drives the byte register port directly; checker bound at the foot.
`include "synth_lock_phase_regs_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, arst_n = 0, wr_en = 0, rd_en = 0, lock_lost_event = 0;
	logic [7:0] addr = 8'h00, wr_data = 8'h00;
	wire [7:0] rd_data;
	wire lock_lost_sticky, lock_lost_clear, osc_driver_disable, master_osc_drive_en;
	wire [12:0] coarse_offset_div_c, coarse_offset_div_d;
	wire [2:0] eighth_turn_offset_div_c, eighth_turn_offset_div_d;
	wire signed [3:0] eighth_turn_steps_div_c, eighth_turn_steps_div_d;
	logic [31:0] steps_tbl = 32'h1234def0;
	int fail_count = 0, samples_checked = 0;
	synth_lock_phase_regs synth_lock_phase_regs_i (
		.mclk(mclk),
		.arst_n(arst_n),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.addr(addr),
		.wr_data(wr_data),
		.lock_lost_event(lock_lost_event),
		.rd_data(rd_data),
		.lock_lost_sticky(lock_lost_sticky),
		.lock_lost_clear(lock_lost_clear),
		.coarse_offset_div_c(coarse_offset_div_c),
		.eighth_turn_offset_div_c(eighth_turn_offset_div_c),
		.eighth_turn_steps_div_c(eighth_turn_steps_div_c),
		.coarse_offset_div_d(coarse_offset_div_d),
		.eighth_turn_offset_div_d(eighth_turn_offset_div_d),
		.eighth_turn_steps_div_d(eighth_turn_steps_div_d),
		.osc_driver_disable(osc_driver_disable),
		.master_osc_drive_en(master_osc_drive_en)
	);
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1 {wr_en, addr, wr_data} = {1'h1, a, d};
		@(posedge mclk) #1 wr_en = 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk) #1 {rd_en, addr} = {1'h1, a};
		@(posedge mclk) #1 rd_en = 0;
		chk(rd_data, e);
	endtask
	task ev;
		@(posedge mclk) #1 lock_lost_event = 1;
		@(posedge mclk) #1 lock_lost_event = 0;
	endtask
	task summarize;
		$display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial forever #12.5 mclk = ~mclk;
	initial begin
		#100us;
		fail_count++;
		summarize;
	end
	initial begin
		repeat (6) @(posedge mclk);
		#1 arst_n = 1;
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h01);
		chk(lock_lost_sticky, 16'h0001);
		chk(master_osc_drive_en, 16'h0001);
		wr(`ADDR_LOCK_LOSS_CLEAR, 8'h01);
		chk(lock_lost_clear, 16'h0001);
		ev;
		chk(lock_lost_sticky, 16'h0000);
		rd(`ADDR_LOCK_LOSS_CLEAR, 8'h01);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h00);
		wr(`ADDR_LOCK_LOSS_CLEAR, 8'h00);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h00);
		ev;
		chk(lock_lost_sticky, 16'h0001);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h01);
		wr(`ADDR_PHASE_C_LO, 8'hff);
		chk(coarse_offset_div_c, 16'h0000);
		wr(`ADDR_PHASE_C_HI, 8'h9f);
		chk({eighth_turn_offset_div_c, coarse_offset_div_c}, 16'h9fff);
		chk({12'h000, eighth_turn_steps_div_c}, 16'h0004);
		for (int k = 0; k < 8; k++) begin
			wr(`ADDR_PHASE_D_LO, 8'(k));
			wr(`ADDR_PHASE_D_HI, {3'(k), 5'h01});
			chk({12'h000, eighth_turn_steps_div_d}, {12'h000, steps_tbl[4*k +: 4]});
			chk(eighth_turn_offset_div_d, 16'(k));
			chk(coarse_offset_div_d, {8'h01, 8'(k)});
		end
		rd(`ADDR_PHASE_D_HI, 8'he1);
		rd(`ADDR_PHASE_C_LO, 8'hff);
		wr(`ADDR_OSC_SELECT, 8'h01);
		rd(`ADDR_OSC_SELECT, 8'h01);
		chk(osc_driver_disable, 16'h0001);
		chk(master_osc_drive_en, 16'h0000);
		wr(`ADDR_OSC_SELECT, 8'h00);
		rd(8'he0, 8'h00);
		chk(master_osc_drive_en, 16'h0001);
		wr(`ADDR_LOCK_LOSS_STATUS, 8'h00);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h01);
		wr(`ADDR_LOCK_LOSS_CLEAR, 8'h01);
		wr(`ADDR_LOCK_LOSS_CLEAR, 8'h00);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h00);
		wr(`ADDR_OSC_SELECT, 8'h01);
		@(posedge mclk) #1 arst_n = 0;
		@(posedge mclk) #1 arst_n = 1;
		chk(lock_lost_sticky, 16'h0001);
		chk(master_osc_drive_en, 16'h0001);
		chk({eighth_turn_offset_div_c, coarse_offset_div_c}, 16'h0000);
		rd(`ADDR_OSC_SELECT, 8'h00);
		rd(`ADDR_LOCK_LOSS_STATUS, 8'h01);
		summarize;
	end
endmodule
bind synth_lock_phase_regs synth_lock_phase_regs_props synth_lock_phase_regs_props_i (
	.mclk(mclk),
	.arst_n(arst_n),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.lock_lost_event(lock_lost_event),
	.addr(addr),
	.wr_data(wr_data),
	.rd_data(rd_data),
	.lock_lost_sticky(lock_lost_sticky),
	.lock_lost_clear(lock_lost_clear),
	.coarse_offset_div_c(coarse_offset_div_c),
	.eighth_turn_offset_div_c(eighth_turn_offset_div_c),
	.eighth_turn_steps_div_c(eighth_turn_steps_div_c),
	.coarse_offset_div_d(coarse_offset_div_d),
	.eighth_turn_offset_div_d(eighth_turn_offset_div_d),
	.eighth_turn_steps_div_d(eighth_turn_steps_div_d),
	.osc_driver_disable(osc_driver_disable),
	.master_osc_drive_en(master_osc_drive_en)
);
